/* rtl/max_lock_pkg.sv */
/*
  Package for the max-address lock state machine: command codes, feature
  codes, flag bit positions, counter reload and the taskfile carrier structs.
  Assumes a taskfile front end that presents one decoded command per strobe.
*/
package max_lock_pkg;

  // ----------------------------------------------------------------------
  // command and feature codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_SET_MAX = 8'hF9;
  localparam logic [7:0] OPC_READ_NATIVE_MAX = 8'hF8;
  localparam logic [7:0] FEAT_SET_PASSWORD = 8'h01;
  localparam logic [7:0] FEAT_LOCK = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] FEAT_FREEZE = 8'h04;

  // ----------------------------------------------------------------------
  // flag bit positions and reset values
  // ----------------------------------------------------------------------
  localparam int ERR_ABORT_BIT = 2;
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_DRQ_BIT = 3;
  localparam int STAT_ERROR_BIT = 0;
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h40;

  // ----------------------------------------------------------------------
  // password sector layout, counter
  // ----------------------------------------------------------------------
  localparam int SECTOR_WORDS = 256;
  localparam int PWD_FIRST_WORD = 1;
  localparam int PWD_LAST_WORD = 16;
  localparam int PWD_WORDS = 16;
  localparam logic [2:0] UNLOCK_TRIES_RESET = 3'h5;

  typedef enum logic [1:0] {
    LOCK_UNLOCKED,
    LOCK_LOCKED,
    LOCK_FROZEN
  } lock_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] feature;
  } taskfile_cmd_t;

  typedef struct packed {
    logic [7:0] error;
    logic [7:0] status;
  } taskfile_resp_t;

endpackage

/* rtl/max_address_lock_state_machine.sv */
/*
  Command state machine guarding the max-address security sub-commands.
  Assumes the taskfile front end strobes each written command once and
  streams data-out words, gaps allowed, on data_valid_i while this block raises drq.
*/
// Summary of operation
// - feature 02h lock, 03h unlock, 04h freeze lock are decoded.
// - all sub-commands share opcode F9h.
// - F9h right after read-native-max is a set-max-address command.
// - successful lock enters the locked state.
// - locked rejects all set-max commands but unlock and freeze.
// - locked persists until reset, accepted unlock or freeze.
// - unlock takes one full data sector before it is evaluated.
// - password mismatch aborts unlock and decrements the attempt counter.
// - attempt counter starts at 5, minus one per mismatch.
// - counter at zero rejects every unlock until hard reset.
// - password match enters unlocked; all set-max commands but a zero-counter unlock or an undecoded feature code accepted.
// - freeze lock enters frozen; later set-max commands rejected.
// - frozen refuses set-address, set-password, lock and unlock.
// - feature 01h selects set-password, decoded with the others.
// - stored password lives only until power cycle or reset.
// - accepted set-password leaves the device unlocked.
`timescale 1ns/1ps
module max_address_lock_state_machine
  import max_lock_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire max_lock_pkg::taskfile_cmd_t cmd_i,
  input wire logic data_valid_i,
  input wire logic [15:0] data_i,
  output logic data_ready_o,
  output max_lock_pkg::taskfile_resp_t resp_o,
  output logic done_o,
  output logic set_address_o,
  output max_lock_pkg::lock_state_t lock_state_o,
  output logic [2:0] unlock_tries_o
);
  import max_lock_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DATA,
    SEQ_EVAL
  } seq_state_t;

  seq_state_t seq_r, seq_nxt;
  lock_state_t lock_r, lock_nxt;
  logic [2:0] tries_r, tries_nxt;
  logic native_read_r, native_read_nxt;
  logic pwd_valid_r, pwd_valid_nxt;
  logic is_unlock_r, is_unlock_nxt;
  logic mismatch_r, mismatch_nxt;
  logic [7:0] word_cnt_r, word_cnt_nxt;
  logic [7:0] err_r, err_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic done_r, done_nxt;
  logic set_addr_r, set_addr_nxt;
  logic [15:0] pwd_r [PWD_WORDS];
  logic [15:0] pwd_nxt [PWD_WORDS];

  function automatic logic in_pwd(input logic [7:0] w);
    in_pwd = (w >= 8'(PWD_FIRST_WORD)) && (w <= 8'(PWD_LAST_WORD));
  endfunction

  function automatic logic [7:0] flags(input logic err, input logic drq);
    logic [7:0] s;
    s = STAT_RESET;
    s[STAT_ERROR_BIT] = err;
    s[STAT_DRQ_BIT] = drq;
    flags = s;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    seq_nxt = seq_r;
    lock_nxt = lock_r;
    tries_nxt = tries_r;
    native_read_nxt = native_read_r;
    pwd_valid_nxt = pwd_valid_r;
    is_unlock_nxt = is_unlock_r;
    mismatch_nxt = mismatch_r;
    word_cnt_nxt = word_cnt_r;
    err_nxt = err_r;
    stat_nxt = stat_r;
    done_nxt = 1'b0;
    set_addr_nxt = 1'b0;
    pwd_nxt = pwd_r;
    case (seq_r)
      SEQ_IDLE: begin
        if (cmd_valid_i) begin
          native_read_nxt = (cmd_i.opcode == OPC_READ_NATIVE_MAX);
          err_nxt = ERR_RESET;
          stat_nxt = flags(1'b0, 1'b0);
          done_nxt = 1'b1;
          if (cmd_i.opcode == OPC_SET_MAX) begin
            if (native_read_r) begin
              if (lock_r != LOCK_UNLOCKED) begin
                err_nxt[ERR_ABORT_BIT] = 1'b1;
                stat_nxt = flags(1'b1, 1'b0);
              end else begin
                set_addr_nxt = 1'b1;
              end
            end else begin
              // every sub-command refused unless a case below accepts it
              err_nxt[ERR_ABORT_BIT] = 1'b1;
              stat_nxt = flags(1'b1, 1'b0);
              case (cmd_i.feature)
                FEAT_SET_PASSWORD, FEAT_UNLOCK: begin
                  // both need a sector; unlock only while tries remain
                  if ((cmd_i.feature == FEAT_SET_PASSWORD &&
                       lock_r == LOCK_UNLOCKED) ||
                      (cmd_i.feature == FEAT_UNLOCK &&
                       lock_r != LOCK_FROZEN &&
                       tries_r != 3'h0)) begin
                    err_nxt = ERR_RESET;
                    stat_nxt = flags(1'b0, 1'b1);
                    done_nxt = 1'b0;
                    seq_nxt = SEQ_DATA;
                    word_cnt_nxt = 8'h00;
                    mismatch_nxt = 1'b0;
                    is_unlock_nxt = (cmd_i.feature == FEAT_UNLOCK);
                  end
                end
                FEAT_LOCK: begin
                  if (lock_r == LOCK_UNLOCKED) begin
                    err_nxt = ERR_RESET;
                    stat_nxt = flags(1'b0, 1'b0);
                    lock_nxt = LOCK_LOCKED;
                  end
                end
                FEAT_FREEZE: begin
                  if (lock_r != LOCK_FROZEN) begin
                    err_nxt = ERR_RESET;
                    stat_nxt = flags(1'b0, 1'b0);
                    lock_nxt = LOCK_FROZEN;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
      end
      SEQ_DATA: begin
        if (data_valid_i) begin
          if (in_pwd(word_cnt_r)) begin
            if (is_unlock_r) begin
              if (!pwd_valid_r ||
                  pwd_r[4'(word_cnt_r - 8'h01)] != data_i) begin
                mismatch_nxt = 1'b1;
              end
            end else begin
              pwd_nxt[4'(word_cnt_r - 8'h01)] = data_i;
            end
          end
          word_cnt_nxt = word_cnt_r + 8'h01;
          if (word_cnt_r == 8'(SECTOR_WORDS - 1)) begin
            seq_nxt = SEQ_EVAL;
            stat_nxt = flags(1'b0, 1'b0);
          end
        end
      end
      SEQ_EVAL: begin
        seq_nxt = SEQ_IDLE;
        done_nxt = 1'b1;
        if (!is_unlock_r) begin
          pwd_valid_nxt = 1'b1;
          lock_nxt = LOCK_UNLOCKED;
        end else if (mismatch_r) begin
          err_nxt[ERR_ABORT_BIT] = 1'b1;
          stat_nxt = flags(1'b1, 1'b0);
          tries_nxt = tries_r - 3'h1;
        end else begin
          lock_nxt = LOCK_UNLOCKED;
        end
      end
      default: seq_nxt = SEQ_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // registers; reset also discards the password, it is never kept
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      seq_r <= SEQ_IDLE;
      lock_r <= LOCK_UNLOCKED;
      tries_r <= UNLOCK_TRIES_RESET;
      native_read_r <= 1'b0;
      pwd_valid_r <= 1'b0;
      is_unlock_r <= 1'b0;
      mismatch_r <= 1'b0;
      word_cnt_r <= 8'h00;
      err_r <= ERR_RESET;
      stat_r <= STAT_RESET;
      done_r <= 1'b0;
      set_addr_r <= 1'b0;
      for (int i = 0; i < PWD_WORDS; i++) begin
        pwd_r[i] <= 16'h0000;
      end
    end else begin
      seq_r <= seq_nxt;
      lock_r <= lock_nxt;
      tries_r <= tries_nxt;
      native_read_r <= native_read_nxt;
      pwd_valid_r <= pwd_valid_nxt;
      is_unlock_r <= is_unlock_nxt;
      mismatch_r <= mismatch_nxt;
      word_cnt_r <= word_cnt_nxt;
      err_r <= err_nxt;
      stat_r <= stat_nxt;
      done_r <= done_nxt;
      set_addr_r <= set_addr_nxt;
      pwd_r <= pwd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs; busy shows only in the evaluation cycle after the data sector
  // ----------------------------------------------------------------------
  always_comb begin
    resp_o.error = err_r;
    resp_o.status = stat_r;
    resp_o.status[STAT_BUSY_BIT] = (seq_r == SEQ_EVAL);
  end
  assign data_ready_o = (seq_r == SEQ_DATA);
  assign done_o = done_r;
  assign set_address_o = set_addr_r;
  assign lock_state_o = lock_r;
  assign unlock_tries_o = tries_r;

endmodule // max_address_lock_state_machine

/* tb/max_lock_assertions.sv */
/* Checker for the max-address lock machine: state and response relations.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module max_lock_assertions (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire max_lock_pkg::taskfile_cmd_t cmd_i,
  input wire logic data_ready_o,
  input wire max_lock_pkg::taskfile_resp_t resp_o,
  input wire logic done_o,
  input wire logic set_address_o,
  input wire max_lock_pkg::lock_state_t lock_state_o,
  input wire logic [2:0] unlock_tries_o
);
  import max_lock_pkg::*;
  logic idle;
  logic last_f8_r;
  assign idle = cmd_valid_i && !data_ready_o && !resp_o.status[STAT_BUSY_BIT];
  // ----------------------------------------------------------------
  // helper: remembers a read-native-max as the last command taken
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) last_f8_r <= 1'b0;
    else if (idle) last_f8_r <= cmd_i.opcode == OPC_READ_NATIVE_MAX;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_any;
    idle && !last_f8_r && cmd_i.opcode == OPC_SET_MAX;
  endsequence
  sequence s_cmd(logic [7:0] f);
    s_any ##0 cmd_i.feature == f;
  endsequence
  AST_ABORT_PAIR: assert property (
    done_o |-> !resp_o.status[STAT_BUSY_BIT] &&
      resp_o.status[STAT_ERROR_BIT] == resp_o.error[ERR_ABORT_BIT])
    else $error("abort and error flags disagree");
  AST_LOCK_ENTER: assert property (
    s_cmd(FEAT_LOCK) ##0 lock_state_o == LOCK_UNLOCKED |=> done_o &&
      lock_state_o == LOCK_LOCKED && resp_o.status == STAT_RESET)
    else $error("lock not entered");
  AST_LOCKED_REJECT: assert property (
    s_cmd(FEAT_LOCK) ##0 lock_state_o == LOCK_LOCKED |=> done_o &&
      resp_o.error == 8'h04 && lock_state_o == LOCK_LOCKED)
    else $error("lock accepted while locked");
  AST_UNLOCK_DATA: assert property (
    s_cmd(FEAT_UNLOCK) ##0 (unlock_tries_o != 3'h0 &&
      lock_state_o != LOCK_FROZEN) |=> data_ready_o && !done_o)
    else $error("unlock did not ask for data");
  AST_TRIES_STEP: assert property (
    !$past(sys_rst_i) && unlock_tries_o != $past(unlock_tries_o) |->
      unlock_tries_o == $past(unlock_tries_o) - 3'h1 && done_o &&
      resp_o.error[ERR_ABORT_BIT])
    else $error("attempt counter moved wrongly");
  AST_NO_TRIES: assert property (
    s_cmd(FEAT_UNLOCK) ##0 unlock_tries_o == 3'h0 |=> done_o &&
      resp_o.error == 8'h04 && resp_o.status == 8'h41)
    else $error("unlock taken with no attempts left");
  AST_FROZEN_STAYS: assert property (
    lock_state_o == LOCK_FROZEN |=> lock_state_o == LOCK_FROZEN)
    else $error("frozen state left");
  AST_FROZEN_REFUSE: assert property (
    s_any ##0 lock_state_o == LOCK_FROZEN |=> done_o &&
      resp_o.error[ERR_ABORT_BIT])
    else $error("command accepted while frozen");
  AST_SET_ADDR: assert property (
    idle && last_f8_r && cmd_i.opcode == OPC_SET_MAX &&
      lock_state_o == LOCK_UNLOCKED |=> set_address_o)
    else $error("set address not taken");
  AST_RESET_STATE: assert property (disable iff (1'b0)
    sys_rst_i |=> lock_state_o == LOCK_UNLOCKED && !done_o &&
      unlock_tries_o == UNLOCK_TRIES_RESET && resp_o == {ERR_RESET, STAT_RESET})
    else $error("reset state wrong");
endmodule // max_lock_assertions
bind max_address_lock_state_machine max_lock_assertions
  max_lock_assertions_inst (.clk_i, .sys_rst_i, .cmd_valid_i, .cmd_i,
  .data_ready_o, .resp_o, .done_o, .set_address_o, .lock_state_o,
  .unlock_tries_o);

/* tb/taskfile_host_model.sv */
/* Host model: writes commands and streams data-out sectors with gaps.
   Assumes run() is called from one process at a time. */
`timescale 1ns/1ps
module taskfile_host_model (
  input wire logic clk_i,
  input wire logic data_ready_i,
  input wire logic done_i,
  output logic cmd_valid_o = 1'b0,
  output max_lock_pkg::taskfile_cmd_t cmd_o = '0,
  output logic data_valid_o = 1'b0,
  output logic [15:0] data_o = 16'h0000
);
  import max_lock_pkg::*;
  logic [31:0] lf = 32'hB0741402;
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    lfsr_step = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // ----------------------------------------------------------------
  // one command; a data command sends one whole sector
  // ----------------------------------------------------------------
  task automatic run(input logic [7:0] op, input logic [7:0] f,
      input logic [15:0] pw, input bit dat);
    int n = 0;
    bit tk = 1'b0;
    cmd_valid_o <= 1'b1;
    cmd_o <= {op, f};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    while (dat && n < SECTOR_WORDS) begin
      // a word offered is held until taken, gaps come from the lfsr
      if (!data_valid_o || tk) begin
        lf = lfsr_step(lf);
        data_valid_o <= lf[0] | lf[1];
        data_o <= !(lf[0] | lf[1]) ? ~data_o :
          (n >= PWD_FIRST_WORD && n <= PWD_LAST_WORD) ? pw ^ 16'(n) : lf[31:16];
      end
      @(negedge clk_i);
      tk = data_valid_o && data_ready_i;
      @(posedge clk_i);
      n += int'(tk);
    end
    data_valid_o <= 1'b0;
    data_o <= ~data_o;
    // no local limit: a missing completion is left to the bench watchdog
    do @(negedge clk_i); while (!done_i);
    @(posedge clk_i);
  endtask
endmodule // taskfile_host_model

/* tb/max_address_lock_state_machine_test.sv */
/* Self-checking bench for the max-address lock machine and host model.
   Assumes a 20 MHz clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module max_address_lock_state_machine_test;
  import max_lock_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid_i, data_valid_i, data_ready_o, done_o, set_address_o;
  logic [15:0] data_i;
  logic [2:0] unlock_tries_o;
  taskfile_cmd_t cmd_i;
  taskfile_resp_t resp_o;
  lock_state_t lock_state_o;
  logic [21:0] q[$];
  int errors = 0;
  int n_compared = 0;
  always #25 clk_i = ~clk_i;
  max_address_lock_state_machine max_address_lock_state_machine_inst (
    .clk_i, .sys_rst_i, .cmd_valid_i, .cmd_i, .data_valid_i, .data_i,
    .data_ready_o, .resp_o, .done_o, .set_address_o, .lock_state_o,
    .unlock_tries_o);
  taskfile_host_model taskfile_host_model_inst (.clk_i,
    .data_ready_i(data_ready_o), .done_i(done_o), .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i), .data_valid_o(data_valid_i), .data_o(data_i));
  task automatic check(input logic [21:0] exp);
    n_compared++;
    if ({set_address_o, resp_o, lock_state_o, unlock_tries_o} !== exp) begin
      errors++;
      $display("BAD %0t want %h", $time, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (q.size() != 0) begin
      errors++;
      $display("BAD %0t %0d results never came", $time, q.size());
    end
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge clk_i) begin
    if (done_o === 1'b1) check(q.size() ? q.pop_front() : 'x);
  end
  task automatic rst;
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    check({1'b0, ERR_RESET, STAT_RESET, LOCK_UNLOCKED,
      UNLOCK_TRIES_RESET});
    @(posedge clk_i);
  endtask
  task automatic issue(input logic [7:0] op, input logic [7:0] f,
      input logic [15:0] pw, input bit d, input bit ab, input bit sa,
      input lock_state_t lk, input logic [2:0] tr);
    q.push_back({sa, ab ? 8'h04 : 8'h00, ab ? 8'h41 : 8'h40, lk, tr});
    taskfile_host_model_inst.run(op, f, pw, d);
    $display("test with opcode %h feature %h ended", op, f);
  endtask
  task automatic step(input logic [7:0] f, input logic [15:0] pw,
      input bit d, input bit ab, input lock_state_t lk, input logic [2:0] tr);
    issue(OPC_SET_MAX, f, pw, d, ab, 1'b0, lk, tr);
  endtask
  initial begin
    rst();
    step(FEAT_UNLOCK, 16'h1234, 1'h1, 1'h1, LOCK_UNLOCKED, 3'h4);
    step(FEAT_SET_PASSWORD, 16'h1234, 1'h1, 1'h0,
      LOCK_UNLOCKED, 3'h4);
    step(FEAT_LOCK, 16'h0000, 1'h0, 1'h0, LOCK_LOCKED, 3'h4);
    step(FEAT_LOCK, 16'h0000, 1'h0, 1'h1, LOCK_LOCKED, 3'h4);
    step(FEAT_UNLOCK, 16'h4321, 1'h1, 1'h1, LOCK_LOCKED, 3'h3);
    step(FEAT_UNLOCK, 16'h1234, 1'h1, 1'h0, LOCK_UNLOCKED, 3'h3);
    step(8'h05, 16'h0000, 1'h0, 1'h1, LOCK_UNLOCKED, 3'h3);
    issue(OPC_READ_NATIVE_MAX, 8'h00, 16'h0, 1'h0, 1'h0, 1'h0,
      LOCK_UNLOCKED, 3'h3);
    issue(OPC_SET_MAX, 8'h00, 16'h0, 1'h0, 1'h0, 1'h1,
      LOCK_UNLOCKED, 3'h3);
    step(FEAT_LOCK, 16'h0000, 1'h0, 1'h0, LOCK_LOCKED, 3'h3);
    issue(OPC_READ_NATIVE_MAX, 8'h00, 16'h0, 1'h0, 1'h0, 1'h0,
      LOCK_LOCKED, 3'h3);
    issue(OPC_SET_MAX, 8'h00, 16'h0, 1'h0, 1'h1, 1'h0,
      LOCK_LOCKED, 3'h3);
    step(FEAT_FREEZE, 16'h0000, 1'h0, 1'h0, LOCK_FROZEN, 3'h3);
    for (int f = 1; f <= 4; f++)
      step(8'(f), 16'h1234, 1'h0, 1'h1, LOCK_FROZEN, 3'h3);
    issue(OPC_READ_NATIVE_MAX, 8'h00, 16'h0, 1'h0, 1'h0, 1'h0,
      LOCK_FROZEN, 3'h3);
    issue(OPC_SET_MAX, 8'h00, 16'h0, 1'h0, 1'h1, 1'h0,
      LOCK_FROZEN, 3'h3);
    rst();
    for (int i = 0; i < 5; i++)
      step(FEAT_UNLOCK, 16'h1234, 1'h1, 1'h1, LOCK_UNLOCKED,
        3'(4 - i));
    step(FEAT_UNLOCK, 16'h1234, 1'h0, 1'h1, LOCK_UNLOCKED, 3'h0);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
endmodule // max_address_lock_state_machine_test
